// ### core/arc_clk_if.sv
`timescale 1ns/1ps
// Clock selection settings in, converter clock enable out
interface arc_clk_if;
	logic [1:0] src_sel;   // Input clock source
	logic [1:0] div_sel;   // Divide ratio select
	logic       conv_tick; // Converter clock enable pulse

	modport ctrl (output src_sel, output div_sel, input conv_tick);
	modport gen  (input src_sel, input div_sel, output conv_tick);
endinterface

// ### core/arc_clkdiv.sv
`timescale 1ns/1ps
// Converter clock enable: source select followed by a 1/2/4/8 divider
module arc_clkdiv (
	input  wire logic clk_in,
	input  wire logic rstn_in,
	input  wire logic alt_tick_in,
	input  wire logic async_tick_in,
	arc_clk_if.gen    ck
);
	logic       half_q;  // Bus clock halving toggle
	logic       half_d;
	logic [2:0] cnt_q;   // Source ticks seen in this converter period
	logic [2:0] cnt_d;
	logic       tick_q;  // Registered enable pulse
	logic       tick_d;
	logic       src_tick; // Selected source tick

	// Ratio minus one for the divide select code
	function automatic logic [2:0] div_last(input logic [1:0] sel);
		case (sel)
			2'h0:    div_last = 3'h0;
			2'h1:    div_last = 3'h1;
			2'h2:    div_last = 3'h3;
			default: div_last = 3'h7;
		endcase
	endfunction

	// Source mux; alternate and internal clocks arrive as ticks of this clock
	always_comb begin
		case (arc_pkg::arc_src_t'(ck.src_sel))
			arc_pkg::ARC_SRC_BUS:      src_tick = 1'b1;
			arc_pkg::ARC_SRC_BUS_HALF: src_tick = half_q;
			arc_pkg::ARC_SRC_ALT:      src_tick = alt_tick_in;
			arc_pkg::ARC_SRC_ASYNC:    src_tick = async_tick_in;
			default:                   src_tick = 1'b0;
		endcase
	end

	// Next-state of the divider
	always_comb begin
		half_d = ~half_q;
		cnt_d  = cnt_q;
		tick_d = 1'b0;
		if (src_tick) begin
			// Counter at or above the limit wraps, so a ratio change never hangs it
			if (cnt_q >= div_last(ck.div_sel)) begin
				cnt_d  = 3'h0;
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 3'h1;
			end
		end
	end

	// Registers only
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			half_q <= 1'b0;
			cnt_q  <= 3'h0;
			tick_q <= 1'b0;
		end else begin
			half_q <= half_d;
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign ck.conv_tick = tick_q;
endmodule

// ### core/arc_pkg.sv
package arc_pkg;
	// Register index map, one byte each
	localparam logic [2:0] ADDR_RES_HIGH = 3'h0;
	localparam logic [2:0] ADDR_RES_LOW  = 3'h1;
	localparam logic [2:0] ADDR_CMP_HIGH = 3'h2;
	localparam logic [2:0] ADDR_CMP_LOW  = 3'h3;
	localparam logic [2:0] ADDR_CONFIG   = 3'h4;
	localparam logic [2:0] ADDR_PIN_LO   = 3'h5;

	// Configuration field positions
	localparam int CFG_LOW_POWER_BIT = 7;
	localparam int CFG_DIV_HI        = 6;
	localparam int CFG_DIV_LO        = 5;
	localparam int CFG_LONG_SMP_BIT  = 4;
	localparam int CFG_MODE_HI       = 3;
	localparam int CFG_MODE_LO       = 2;
	localparam int CFG_CLK_HI        = 1;
	localparam int CFG_CLK_LO        = 0;

	// Conversion width encodings
	localparam logic [1:0] MODE_8BIT  = 2'h0;
	localparam logic [1:0] MODE_10BIT = 2'h2;

	// Reset values
	localparam logic [7:0] RST_CONFIG  = 8'h00;
	localparam logic [7:0] RST_CMP     = 8'h00;
	localparam logic [7:0] RST_PIN     = 8'h00;
	localparam logic [9:0] RST_RESULT  = 10'h000;
	localparam logic [7:0] READ_ZERO   = 8'h00;

	// Input clock source choices
	typedef enum logic [1:0] {
		ARC_SRC_BUS      = 2'b00,
		ARC_SRC_BUS_HALF = 2'b01,
		ARC_SRC_ALT      = 2'b10,
		ARC_SRC_ASYNC    = 2'b11
	} arc_src_t;
endpackage

// ### core/arc_regs.sv
`timescale 1ns/1ps
// Operation
// - Low result byte holds low eight bits
// - Results update unless compare enabled and fails
// - Ten-bit high read blocks updates until low read
// - Blocked completion result is discarded
// - Eight-bit mode has no read interlock
// - Width change invalidates low result byte; code keeps the byte readable and only drops the interlock
// - Compare high holds upper two bits, ten-bit
// - Eight-bit compare ignores compare high register
// - Compare low checked against low eight bits
// - Config bit 7 selects low power
// - Config bits 6:5 divide by 1/2/4/8
// - Config bit 4 selects long sample
// - Config bits 3:2 select conversion width
// - Config bits 1:0 select input clock
// - Pin control bit n disables channel n I/O
// - Disabled pin: high-z, read zero, no pullup
// - Compare less-than, or greater-equal when selected
// - Eight-bit mode upper result bits read zero
module arc_regs (
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	// Register port
	input  wire logic [2:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic      [7:0] rdata_out,
	// Converter side
	input  wire logic       conv_done_in,
	input  wire logic [9:0] conv_result_in,
	input  wire logic       compare_enable_in,
	input  wire logic       compare_greater_select_in,
	input  wire logic       alt_tick_in,
	input  wire logic       async_tick_in,
	output logic            converter_clock_en_out,
	output logic            low_power_select_out,
	output logic            long_sample_select_out,
	output logic            ten_bit_mode_out,
	output logic            compare_match_out,
	// Port pin side, channels 0 to 7
	input  wire logic [7:0] port_dout_in,
	input  wire logic [7:0] port_oe_in,
	input  wire logic [7:0] port_pullup_in,
	input  wire logic [7:0] pad_in,
	output logic      [7:0] pad_dout_out,
	output logic      [7:0] pad_oe_out,
	output logic      [7:0] pad_pullup_out,
	output logic      [7:0] port_din_out,
	output logic      [7:0] pin_disable_out
);
	// Software registers
	logic [7:0] cfg_q;     // Converter configuration
	logic [7:0] cfg_d;
	logic [7:0] cmp_hi_q;  // Compare value high
	logic [7:0] cmp_hi_d;
	logic [7:0] cmp_lo_q;  // Compare value low
	logic [7:0] cmp_lo_d;
	logic [7:0] pin_q;     // Analog pin control for channels 0 to 7
	logic [7:0] pin_d;
	// Result state
	logic [9:0] result_q;  // Captured result, ten bits
	logic [9:0] result_d;
	logic       lock_q;    // High byte read, waiting for low byte read
	logic       lock_d;
	logic       match_q;   // Last completion had compare enabled and met the compare condition
	logic       match_d;
	// Read answer
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	// Decode helpers
	logic       ten_bit;   // Ten-bit width selected
	logic       cmp_cond;  // Compare condition for the arriving result
	logic       take;      // Arriving result is stored
	logic       mode_wr;   // Write that changes the width field
	logic [9:0] cmp_val;   // Compare value at the current width
	logic [9:0] res_val;   // Arriving result at the current width

	arc_clk_if ck ();

	// Converter clock enable generator
	arc_clkdiv u_clkdiv (
		.clk_in        (clk_in),
		.rstn_in       (rstn_in),
		.alt_tick_in   (alt_tick_in),
		.async_tick_in (async_tick_in),
		.ck            (ck.gen)
	);

	// Byte register address decode
	function automatic logic hit(input logic [2:0] a, input logic [2:0] reg_addr);
		hit = (a == reg_addr);
	endfunction

	assign ck.src_sel = cfg_q[arc_pkg::CFG_CLK_HI:arc_pkg::CFG_CLK_LO];
	assign ck.div_sel = cfg_q[arc_pkg::CFG_DIV_HI:arc_pkg::CFG_DIV_LO];
	// Reserved width codes fall back to eight-bit behaviour
	assign ten_bit = (cfg_q[arc_pkg::CFG_MODE_HI:arc_pkg::CFG_MODE_LO]
		== arc_pkg::MODE_10BIT);

	// Compare evaluation on the arriving result
	always_comb begin
		if (ten_bit) begin
			cmp_val = {cmp_hi_q[1:0], cmp_lo_q};
			res_val = conv_result_in;
		end else begin
			cmp_val = {2'h0, cmp_lo_q};
			res_val = {2'h0, conv_result_in[7:0]};
		end
		if (compare_greater_select_in) begin
			cmp_cond = (res_val >= cmp_val);
		end else begin
			cmp_cond = (res_val < cmp_val);
		end
	end

	// Store on completion unless compare fails or the interlock holds
	assign take = conv_done_in && (!compare_enable_in || cmp_cond)
		&& !(ten_bit && lock_q);
	assign mode_wr = wr_in && hit(addr_in, arc_pkg::ADDR_CONFIG)
		&& (wdata_in[arc_pkg::CFG_MODE_HI:arc_pkg::CFG_MODE_LO]
		!= cfg_q[arc_pkg::CFG_MODE_HI:arc_pkg::CFG_MODE_LO]);

	// Software register next values
	always_comb begin
		cfg_d    = cfg_q;
		cmp_hi_d = cmp_hi_q;
		cmp_lo_d = cmp_lo_q;
		pin_d    = pin_q;
		if (wr_in) begin
			case (addr_in)
				arc_pkg::ADDR_CMP_HIGH: cmp_hi_d = wdata_in;
				arc_pkg::ADDR_CMP_LOW:  cmp_lo_d = wdata_in;
				arc_pkg::ADDR_CONFIG:   cfg_d    = wdata_in;
				arc_pkg::ADDR_PIN_LO:   pin_d    = wdata_in;
				// Result registers and unmapped offsets drop the write
				default:                cfg_d    = cfg_q;
			endcase
		end
	end

	// Result and interlock next values
	always_comb begin
		result_d = result_q;
		lock_d   = lock_q;
		match_d  = match_q;
		if (conv_done_in) begin
			match_d = compare_enable_in && cmp_cond;
		end
		if (take) begin
			// Eight-bit results keep the upper bits at zero
			result_d = ten_bit ? conv_result_in
				: {2'h0, conv_result_in[7:0]};
		end
		// Low byte read releases, high byte read in ten-bit mode arms
		if (rd_in && hit(addr_in, arc_pkg::ADDR_RES_LOW)) begin
			lock_d = 1'b0;
		end
		if (rd_in && hit(addr_in, arc_pkg::ADDR_RES_HIGH) && ten_bit) begin
			lock_d = 1'b1;
		end
		// Old contents mean nothing at the new width; drop lock so new data lands
		if (mode_wr) begin
			lock_d = 1'b0;
		end
	end

	// Read data, standing only in the cycle after the strobe
	always_comb begin
		rdata_d = arc_pkg::READ_ZERO;
		if (rd_in) begin
			case (addr_in)
				arc_pkg::ADDR_RES_HIGH: begin
					// Upper bits read zero at eight-bit width, even if a stale
					// ten-bit result is still held after a width change
					rdata_d = ten_bit ? {6'h00, result_q[9:8]} : arc_pkg::READ_ZERO;
				end
				arc_pkg::ADDR_RES_LOW:  rdata_d = result_q[7:0];
				arc_pkg::ADDR_CMP_HIGH: rdata_d = cmp_hi_q;
				arc_pkg::ADDR_CMP_LOW:  rdata_d = cmp_lo_q;
				arc_pkg::ADDR_CONFIG:   rdata_d = cfg_q;
				arc_pkg::ADDR_PIN_LO:   rdata_d = pin_q;
				default:                rdata_d = arc_pkg::READ_ZERO;
			endcase
		end
	end

	// All block state except the clock divider's own registers
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			cfg_q    <= arc_pkg::RST_CONFIG;
			cmp_hi_q <= arc_pkg::RST_CMP;
			cmp_lo_q <= arc_pkg::RST_CMP;
			pin_q    <= arc_pkg::RST_PIN;
			result_q <= arc_pkg::RST_RESULT;
			lock_q   <= 1'b0;
			match_q  <= 1'b0;
			rdata_q  <= arc_pkg::READ_ZERO;
		end else begin
			cfg_q    <= cfg_d;
			cmp_hi_q <= cmp_hi_d;
			cmp_lo_q <= cmp_lo_d;
			pin_q    <= pin_d;
			result_q <= result_d;
			lock_q   <= lock_d;
			match_q  <= match_d;
			rdata_q  <= rdata_d;
		end
	end

	// Outputs from the registers, the clock divider and the width decode
	assign rdata_out              = rdata_q;
	assign converter_clock_en_out = ck.conv_tick;
	assign low_power_select_out   = cfg_q[arc_pkg::CFG_LOW_POWER_BIT];
	assign long_sample_select_out = cfg_q[arc_pkg::CFG_LONG_SMP_BIT];
	assign ten_bit_mode_out       = ten_bit;
	assign compare_match_out      = match_q;
	assign pin_disable_out        = pin_q;

	// Pin gating: a set bit takes the pin away from the port logic
	assign pad_dout_out   = port_dout_in & ~pin_q;
	assign pad_oe_out     = port_oe_in & ~pin_q;
	assign pad_pullup_out = port_pullup_in & ~pin_q;
	assign port_din_out   = pad_in & ~pin_q;
endmodule

// ### test/arc_regs_props.sv
`timescale 1ns/1ps
// Port checks for the register block; sees only top-level ports
module arc_regs_props (
	input wire logic       clk_in,
	input wire logic       rstn_in,
	input wire logic [2:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic       wr_in,
	input wire logic       rd_in,
	input wire logic [7:0] rdata_out,
	input wire logic       conv_done_in,
	input wire logic       compare_enable_in,
	input wire logic       low_power_select_out,
	input wire logic       long_sample_select_out,
	input wire logic       ten_bit_mode_out,
	input wire logic       compare_match_out,
	input wire logic [7:0] port_dout_in,
	input wire logic [7:0] port_oe_in,
	input wire logic [7:0] port_pullup_in,
	input wire logic [7:0] pad_in,
	input wire logic [7:0] pad_dout_out,
	input wire logic [7:0] pad_oe_out,
	input wire logic [7:0] pad_pullup_out,
	input wire logic [7:0] port_din_out,
	input wire logic [7:0] pin_disable_out
);
	// One clock domain, reset gates every check
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	AST_PIN_OE:
		assert property (pad_oe_out == (port_oe_in & ~pin_disable_out)) else $error("pad oe");
	AST_PIN_DIN:
		assert property (port_din_out == (pad_in & ~pin_disable_out)) else $error("port din");
	AST_PIN_DOUT:
		assert property (pad_dout_out == (port_dout_in & ~pin_disable_out))
		else $error("pad dout");
	AST_PIN_PULL:
		assert property (pad_pullup_out == (port_pullup_in & ~pin_disable_out))
		else $error("pad pullup");
	AST_PIN_WR:
		assert property (wr_in && addr_in == arc_pkg::ADDR_PIN_LO
			|=> pin_disable_out == $past(wdata_in))
		else $error("pin ctrl");
	AST_LOW_PWR:
		assert property (wr_in && addr_in == arc_pkg::ADDR_CONFIG
			|=> low_power_select_out == $past(wdata_in[7]))
		else $error("low power");
	AST_LONG_SMP:
		assert property (wr_in && addr_in == arc_pkg::ADDR_CONFIG
			|=> long_sample_select_out == $past(wdata_in[4]))
		else $error("long sample");
	AST_WIDTH:
		assert property (wr_in && addr_in == arc_pkg::ADDR_CONFIG
			|=> ten_bit_mode_out == ($past(wdata_in[3:2]) == 2'h2))
		else $error("width");
	AST_HI_ZERO:
		assert property (rd_in && addr_in == arc_pkg::ADDR_RES_HIGH && !ten_bit_mode_out
			|=> rdata_out == 8'h00)
		else $error("hi bits");
	AST_CMP_OFF:
		assert property (conv_done_in && !compare_enable_in |=> !compare_match_out) else $error("match");
	AST_RD_IDLE:
		assert property (!rd_in |=> rdata_out == 8'h00) else $error("rdata idle");
	// Main scenarios reached
	cover property (wr_in && addr_in == arc_pkg::ADDR_PIN_LO);
	cover property (conv_done_in && compare_enable_in);
	cover property (rd_in && addr_in == arc_pkg::ADDR_RES_HIGH && ten_bit_mode_out);
endmodule

bind arc_regs arc_regs_props chk_u (.*);

// ### test/testbench.sv
`timescale 1ns/1ps
// Self-checking bench: behavioural register model compared at each result
module testbench;
	logic       clk_in = 0, rstn_in = 0, wr_in = 0, rd_in = 0, conv_done_in = 0;
	logic       compare_enable_in = 0, compare_greater_select_in = 0;
	logic       alt_tick_in = 0, async_tick_in = 0, converter_clock_en_out;
	logic       low_power_select_out, long_sample_select_out, ten_bit_mode_out, compare_match_out;
	logic [2:0] addr_in = 0;
	logic [7:0] wdata_in = 0, rdata_out, port_dout_in = 0, port_oe_in = 0, port_pullup_in = 0;
	logic [7:0] pad_in = 0, pad_dout_out, pad_oe_out, pad_pullup_out, port_din_out, pin_disable_out;
	logic [9:0] conv_result_in = 0, m_res = 0, n;
	logic [7:0] m_r [0:7] = '{default: 8'h00}; // Model of indices 2..5
	logic [7:0] lf = 8'h52, c;                  // Pseudo-random state
	logic [15:0] t;
	bit         m_lock = 0;                     // Model read interlock
	int         num_errors = 0, samples_checked = 0, cyc = 0;
	arc_regs dut_u (.*);
	// Bus clock
	always #20 clk_in = ~clk_in;
	// Alternate ticks every 4th cycle, async ticks every 2nd
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		alt_tick_in <= (cyc % 4 == 0);
		async_tick_in <= (cyc % 2 == 1);
	end
	function automatic logic [7:0] nx();
		lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
		return lf;
	endfunction
	function automatic bit ten();
		return m_r[4][3:2] == 2'h2;
	endfunction
	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One-cycle write; width change releases the interlock
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1;
		@(posedge clk_in);
		wr_in <= 0;
		if (a == 3'h4 && d[3:2] != m_r[4][3:2]) m_lock = 0;
		if (a > 1 && a < 6) m_r[a] = d;
	endtask
	// One-cycle read, data checked in the following cycle only
	task automatic rd(input logic [2:0] a);
		logic [7:0] e;
		e = (a == 3'h1) ? m_res[7:0] : m_r[a];
		// High byte carries result bits only at ten-bit width
		if (a == 3'h0) e = ten() ? {6'h00, m_res[9:8]} : 8'h00;
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1;
		@(posedge clk_in);
		rd_in <= 0;
		if (a == 0 && ten()) m_lock = 1;
		if (a == 1) m_lock = 0;
		@(negedge clk_in);
		chk("rdata", {2'h0, e}, {2'h0, rdata_out});
	endtask
	// Completion pulse; stored unless compare fails or interlock holds
	task automatic conv(input logic [9:0] r, input bit ce, input bit gt);
		logic [9:0] v, cv;
		bit hit;
		v = ten() ? r : {2'h0, r[7:0]};
		cv = ten() ? {m_r[2][1:0], m_r[3]} : {2'h0, m_r[3]};
		hit = gt ? (v >= cv) : (v < cv);
		@(posedge clk_in);
		conv_done_in <= 1;
		conv_result_in <= r;
		compare_enable_in <= ce;
		compare_greater_select_in <= gt;
		@(posedge clk_in);
		conv_done_in <= 0;
		if ((!ce || hit) && !(ten() && m_lock)) m_res = v;
		@(negedge clk_in);
		chk("match", {9'h0, ce && hit}, {9'h0, compare_match_out});
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Watchdog well beyond the expected run length
	initial begin
		repeat (20000) @(posedge clk_in);
		num_errors++;
		give_verdict();
	end
	initial begin
		repeat (5) @(posedge clk_in);
		rstn_in <= 1;
		for (int a = 0; a < 8; a++) rd(3'(a));
		for (int a = 0; a < 8; a++) begin
			wr(3'(a), (a == 4) ? (nx() & 8'hfb) : nx());
			rd(3'(a));
		end
		// Every source and divide, pulses counted over 64 cycles
		for (int s = 0; s < 4; s++) begin
			for (int d = 0; d < 4; d++) begin
				wr(3'h4, (nx() & 8'h98) | 8'(d << 5) | 8'(s));
				// Register outputs change at the writing edge; look after it
				@(negedge clk_in);
				chk("lp", {9'h0, m_r[4][7]}, {9'h0, low_power_select_out});
				chk("ls", {9'h0, m_r[4][4]}, {9'h0, long_sample_select_out});
				chk("ten", {9'h0, ten()}, {9'h0, ten_bit_mode_out});
				repeat (8) @(negedge clk_in);
				n = 0;
				repeat (64) begin
					@(negedge clk_in);
					n += converter_clock_en_out;
				end
				chk("ticks", 10'(64 / ((1 << d) * (s == 0 ? 1 : s == 2 ? 4 : 2))), n);
			end
		end
		// Ten-bit interlock: result arriving while locked is lost
		wr(3'h4, 8'h08);
		conv({2'h2, nx()}, 0, 0);
		rd(3'h0);
		conv(10'h155, 0, 0);
		rd(3'h1);
		rd(3'h0);
		// Eight-bit: no interlock, upper bits zero
		wr(3'h4, 8'h00);
		rd(3'h0);
		conv(10'h3c7, 0, 0);
		rd(3'h1);
		rd(3'h0);
		// Random compare traffic in both widths, some conversions preceded by a high-byte read
		for (int i = 0; i < 40; i++) begin
			c = nx();
			wr(3'h4, c & 8'h08);
			wr(3'h2, nx());
			wr(3'h3, nx());
			if (c[2]) rd(3'h0);
			t = {nx(), nx()};
			conv(t[9:0], c[0], c[1]);
			rd(3'h0);
			rd(3'h1);
		end
		// Pin control gating of port requests
		repeat (8) begin
			wr(3'h5, nx());
			@(posedge clk_in);
			port_dout_in <= nx();
			port_oe_in <= nx();
			port_pullup_in <= nx();
			pad_in <= nx();
			@(negedge clk_in);
			chk("pin", {2'h0, m_r[5]}, {2'h0, pin_disable_out});
			chk("dout", {2'h0, port_dout_in & ~m_r[5]}, {2'h0, pad_dout_out});
			chk("oe", {2'h0, port_oe_in & ~m_r[5]}, {2'h0, pad_oe_out});
			chk("pull", {2'h0, port_pullup_in & ~m_r[5]}, {2'h0, pad_pullup_out});
			chk("din", {2'h0, pad_in & ~m_r[5]}, {2'h0, port_din_out});
		end
		give_verdict();
	end
endmodule
